// File: core/trc_params.svh
`ifndef TRC_PARAMS_SVH
`define TRC_PARAMS_SVH
`define TRC_CMD_SOFT_RESTART 16'hfe00
`define TRC_CMD_FIFO_MODE_MASK 16'hff00
`define TRC_CMD_FIFO_MODE 16'hca00
`define TRC_MODE_BIT 0
`define TRC_STATUS_POR_BIT 15
`define TRC_CLK_MHZ 200
`define TRC_POR_MAX_MS 150
`define TRC_HW_PULSE_MIN_NS 1000
`define TRC_READY_DELAY_US 1000
`define TRC_HW_PULSE_CYCLES ((`TRC_HW_PULSE_MIN_NS * `TRC_CLK_MHZ + 999) / 1000)
`define TRC_READY_CYCLES (`TRC_READY_DELAY_US * `TRC_CLK_MHZ)
`define TRC_POR_CYCLES (`TRC_POR_MAX_MS * 1000 * `TRC_CLK_MHZ)
`endif

// File: core/trc_pkg.sv
package trc_pkg;
  typedef enum logic [1:0] {
    TRC_HOLD,
    TRC_WAIT,
    TRC_RUN
  } trc_state_t;
endpackage

// File: core/trc_reset_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "trc_params.svh"
// Summary of operation
// - Reset on power-on, supply glitch, soft restart command or low reset pin.
// - Stay in reset while supply below low level, whatever the ramp says.
// - Ignore all command words while a reset event is in progress.
// - Two modes, normal and sensitive; sensitive after any reset.
// - Normal mode disables supply glitch detection.
// - Sensitive mode resets on fast rising supply reaching ramp threshold.
// - Falling supply resets at low level in both modes, and also below 250 mV when normal.
// - Every reset reloads registers, re-selecting sensitive mode.
// - Hardware reset returns logic to defaults and reloads all registers.
// - Ready for operation a fixed delay after reset pin returns high.
// - The soft restart command word triggers a power-on-like reset.
// - Mode command with bit zero set selects normal mode.
// - Soft restart matches power-on fully, including command rejection.
// - Status power-on flag set by reset, cleared by status read.
// - First bit zero means status read, one means control command.
module trc_reset_ctrl
  import trc_pkg::*;
#(
  parameter int unsigned POR_CYCLES = `TRC_POR_CYCLES,
  parameter int unsigned READY_CYCLES = `TRC_READY_CYCLES,
  parameter int unsigned PULSE_CYCLES = `TRC_HW_PULSE_CYCLES
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic reset_in_n,
  input wire logic supply_below_low_in,
  input wire logic ramp_diff_high_in,
  input wire logic supply_fast_rise_in,
  input wire logic supply_below_250mv_in,
  input wire logic cmd_valid_in,
  input wire logic [15:0] cmd_word_in,
  output logic cmd_accept_out,
  output logic chip_reset_out,
  output logic ready_out,
  output logic normal_mode_out,
  output logic status_por_out,
  output logic status_read_out,
  output logic [15:0] ctrl_word_out,
  output logic ctrl_strobe_out
);
  initial begin
    if (POR_CYCLES < 1 || READY_CYCLES < 1 || PULSE_CYCLES < 1) begin
      $error("trc_reset_ctrl: counts must be at least one");
    end
  end

  localparam int CW = 32;

  trc_state_t state_reg;
  logic [CW-1:0] count_reg;
  logic normal_reg;
  logic por_flag_reg;
  logic [CW-1:0] pin_low_reg;
  logic pin_reset_reg;
  logic cause_reg;
  logic [15:0] ctrl_word_reg;
  logic ctrl_strobe_reg;
  logic status_read_reg;
  logic running;
  logic cmd_take;
  logic is_ctrl;
  logic soft_hit;
  logic mode_hit;
  logic glitch_hit;
  logic fall_hit;
  logic cause;
  logic restart;

  function automatic logic is_soft(input logic [15:0] w);
    is_soft = (w == `TRC_CMD_SOFT_RESTART);
  endfunction

  function automatic logic is_mode(input logic [15:0] w);
    is_mode = ((w & `TRC_CMD_FIFO_MODE_MASK) == `TRC_CMD_FIFO_MODE);
  endfunction

  assign running = (state_reg == TRC_RUN);
  assign cmd_take = cmd_valid_in && running;
  assign is_ctrl = cmd_word_in[15];
  assign soft_hit = cmd_take && is_ctrl && is_soft(cmd_word_in);
  assign mode_hit = cmd_take && is_ctrl && is_mode(cmd_word_in);
  assign glitch_hit = !normal_reg && supply_fast_rise_in && ramp_diff_high_in;
  assign fall_hit = normal_reg ? supply_below_250mv_in : supply_below_low_in;

  // Pin reset counts only after a low of the minimum width
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pin_low_reg <= '0;
      pin_reset_reg <= 1'b0;
    end else if (!reset_in_n) begin
      if (pin_low_reg < CW'(PULSE_CYCLES)) begin
        pin_low_reg <= pin_low_reg + 1'b1;
      end
      if (pin_low_reg + 1'b1 >= CW'(PULSE_CYCLES)) begin
        pin_reset_reg <= 1'b1;
      end
    end else begin
      pin_low_reg <= '0;
      pin_reset_reg <= 1'b0;
    end
  end

  assign cause = pin_reset_reg || soft_hit || glitch_hit || fall_hit
    || supply_below_low_in;

  // Registers reload on the same edge that enters reset, not one cycle later
  assign restart = !running || cause;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cause_reg <= 1'b1;
    end else begin
      cause_reg <= cause;
    end
  end

  // Hold while cause lasts, then wait the ready delay before running
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_reg <= TRC_HOLD;
      count_reg <= '0;
    end else begin
      case (state_reg)
        TRC_HOLD: begin
          count_reg <= '0;
          if (!cause_reg && !ramp_diff_high_in && !supply_below_low_in) begin
            state_reg <= TRC_WAIT;
          end
        end
        TRC_WAIT: begin
          if (cause_reg) begin
            state_reg <= TRC_HOLD;
            count_reg <= '0;
          end else if (count_reg + 1'b1 >= CW'(READY_CYCLES)) begin
            state_reg <= TRC_RUN;
          end else begin
            count_reg <= count_reg + 1'b1;
          end
        end
        TRC_RUN: begin
          if (cause) begin
            state_reg <= TRC_HOLD;
          end
        end
        default: begin
          state_reg <= TRC_HOLD;
        end
      endcase
    end
  end

  // Mode bit returns to sensitive whenever the chip is in reset
  always_ff @(posedge mclk_in) begin
    if (reset_in || restart) begin
      normal_reg <= 1'b0;
    end else if (mode_hit) begin
      normal_reg <= cmd_word_in[`TRC_MODE_BIT];
    end
  end

  // Power-on flag: reset sets, status read clears; set wins
  always_ff @(posedge mclk_in) begin
    if (reset_in || restart) begin
      por_flag_reg <= 1'b1;
    end else if (cmd_take && !is_ctrl) begin
      por_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in || restart) begin
      ctrl_word_reg <= '0;
      ctrl_strobe_reg <= 1'b0;
      status_read_reg <= 1'b0;
    end else begin
      ctrl_strobe_reg <= cmd_take && is_ctrl && !soft_hit;
      status_read_reg <= cmd_take && !is_ctrl;
      if (cmd_take && is_ctrl) begin
        ctrl_word_reg <= cmd_word_in;
      end
    end
  end

  assign cmd_accept_out = cmd_take;
  assign chip_reset_out = !running;
  assign ready_out = running;
  assign normal_mode_out = normal_reg;
  assign status_por_out = por_flag_reg;
  assign status_read_out = status_read_reg;
  assign ctrl_word_out = ctrl_word_reg;
  assign ctrl_strobe_out = ctrl_strobe_reg;
endmodule
`default_nettype wire

// File: dv/trc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module trc_host_model (
  input wire logic hold_low_in,
  output logic reset_in_n
);
  // Pin low time is set by the bench; soft restart never goes out from here
  assign reset_in_n = !hold_low_in;
endmodule
`default_nettype wire

// File: dv/trc_reset_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module trc_checker (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic reset_in_n,
  input wire logic supply_below_low_in,
  input wire logic ramp_diff_high_in,
  input wire logic supply_fast_rise_in,
  input wire logic cmd_valid_in,
  input wire logic [15:0] cmd_word_in,
  input wire logic cmd_accept_out,
  input wire logic chip_reset_out,
  input wire logic ready_out,
  input wire logic normal_mode_out,
  input wire logic status_por_out,
  input wire logic status_read_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  chk_accept_gate: assert property (
    cmd_accept_out == (cmd_valid_in && ready_out)) else $error("accept");
  chk_soft_restart: assert property (
    cmd_accept_out && cmd_word_in == 16'hfe00 |=> chip_reset_out && !normal_mode_out)
    else $error("soft");
  chk_mode_normal: assert property (
    cmd_accept_out && cmd_word_in[15:8] == 8'hca && cmd_word_in[0] |=> normal_mode_out)
    else $error("mode");
  chk_pin_reset: assert property (
    !reset_in_n [*4] |-> ##[0:2] chip_reset_out) else $error("pin");
  chk_low_supply: assert property (
    supply_below_low_in |-> ##[0:2] chip_reset_out) else $error("low");
  chk_glitch_sens: assert property (
    !normal_mode_out && supply_fast_rise_in && ramp_diff_high_in |-> ##[0:2] chip_reset_out)
    else $error("glitch");
  chk_status_read: assert property (
    cmd_accept_out && !cmd_word_in[15] |=> status_read_out && !status_por_out)
    else $error("status");
  chk_ready_delay: assert property (
    $rose(ready_out) |-> $past(chip_reset_out, 10)) else $error("ready");
  cover property (cmd_accept_out);
  cover property ($rose(chip_reset_out));
  cover property (normal_mode_out);
endmodule
bind trc_reset_ctrl trc_checker i_chk (.*);
`default_nettype wire

// File: dv/transceiver_reset_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module transceiver_reset_control_tb_top;
  logic mclk_in = 1'h0, reset_in = 1'h1, pin_low = 1'h0, cmd_valid_in = 1'h0;
  logic supply_below_low_in = 1'h0, ramp_diff_high_in = 1'h0, supply_fast_rise_in = 1'h0;
  logic supply_below_250mv_in = 1'h0;
  logic [15:0] cmd_word_in = 16'h0000;
  wire logic reset_in_n, cmd_accept_out, chip_reset_out, ready_out, normal_mode_out;
  wire logic status_por_out, status_read_out, ctrl_strobe_out;
  wire logic [15:0] ctrl_word_out;
  int n_fail = 0;
  int cmp_count = 0;
  trc_host_model i_host (.hold_low_in(pin_low), .reset_in_n);
  trc_reset_ctrl #(.READY_CYCLES(10), .PULSE_CYCLES(4)) i_dut (.mclk_in, .reset_in,
    .reset_in_n, .supply_below_low_in, .ramp_diff_high_in, .supply_fast_rise_in,
    .supply_below_250mv_in, .cmd_valid_in, .cmd_word_in, .cmd_accept_out, .chip_reset_out,
    .ready_out, .normal_mode_out, .status_por_out, .status_read_out, .ctrl_word_out,
    .ctrl_strobe_out);
  initial forever #2.5 mclk_in = ~mclk_in;
  task summarize();
    $display("fails %0d compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wait_rdy();
    for (int i = 0; i < 99; i++) begin
      @(negedge mclk_in);
      if (ready_out === 1'h1) return;
    end
    n_fail++;
    summarize();
  endtask
  task cmd(input logic [15:0] wd, input logic ea);
    @(negedge mclk_in);
    cmd_valid_in = 1'h1;
    cmd_word_in = wd;
    #1 chk(cmd_accept_out, ea);
    @(negedge mclk_in);
    cmd_valid_in = 1'h0;
  endtask
  task t_cmds();
    cmd(16'hca01, 1'h1);
    chk(normal_mode_out, 1'h1);
    cmd(16'h0000, 1'h1);
    chk({status_read_out, status_por_out}, 2'h2);
    cmd(16'h8123, 1'h1);
    chk(ctrl_word_out, 16'h8123);
    chk(ctrl_strobe_out, 1'h1);
    supply_fast_rise_in = 1'h1;
    ramp_diff_high_in = 1'h1;
    repeat (3) @(negedge mclk_in);
    chk(ready_out, 1'h1);
    supply_fast_rise_in = 1'h0;
    ramp_diff_high_in = 1'h0;
    supply_below_250mv_in = 1'h1;
    repeat (3) @(negedge mclk_in);
    chk(chip_reset_out, 1'h1);
    supply_below_250mv_in = 1'h0;
    wait_rdy();
  endtask
  task t_soft();
    cmd(16'hca01, 1'h1);
    chk(normal_mode_out, 1'h1);
    cmd(16'hfe00, 1'h1);
    chk({chip_reset_out, normal_mode_out}, 2'h2);
    cmd(16'hca01, 1'h0);
    wait_rdy();
    chk({normal_mode_out, status_por_out}, 2'h1);
  endtask
  task t_pin(input int k, input logic e);
    @(negedge mclk_in);
    pin_low = 1'h1;
    repeat (k) @(negedge mclk_in);
    pin_low = 1'h0;
    repeat (2) @(negedge mclk_in);
    chk(chip_reset_out, e);
    wait_rdy();
  endtask
  task t_supply(input logic g);
    @(negedge mclk_in);
    supply_fast_rise_in = g;
    ramp_diff_high_in = g;
    supply_below_low_in = !g;
    repeat (20) @(negedge mclk_in);
    chk(chip_reset_out, 1'h1);
    supply_fast_rise_in = 1'h0;
    ramp_diff_high_in = 1'h0;
    supply_below_low_in = 1'h0;
    wait_rdy();
  endtask
  initial begin
    repeat (16) @(negedge mclk_in);
    reset_in = 1'h0;
    wait_rdy();
    t_cmds();
    t_soft();
    t_pin(3, 1'h0);
    t_pin(4, 1'h1);
    t_supply(1'h1);
    t_supply(1'h0);
    summarize();
  end
endmodule
`default_nettype wire
